// ==== core/bst_tap.sv ====
// boundary-scan test access port: tap controller, instruction register,
// bypass stage, boundary register and identification register
// assumes the scan pins are asynchronous to ref_clk_i and that the scan
// clock runs at most at one eighth of the ref_clk_i rate
`timescale 1ns/1ps

// Overview of operation
// [RQ1] the controller acts on mode select only at rising scan clock edges
// [RQ2] after reset: test-logic-reset, idcode current, system logic undisturbed
// [RQ3] select-dr holds test registers; low goes capture-dr, high select-ir
// [RQ4] capture-dr loads the selected register if it can; then shift or exit1
// [RQ5] shift-dr shifts the selected register one stage per rising edge
// [RQ6] exit1-dr goes update or pause; pause holds, high goes exit2-dr
// [RQ7] exit2-dr: high goes update-dr, low returns to shift-dr
// [RQ8] update-dr latches shift stages on the falling edge; then idle or select
// [RQ9] select-ir holds registers; low goes capture-ir, high test-logic-reset
// [RQ10] capture-ir loads the fixed pattern; then exit1-ir or shift-ir
// [RQ11] the fixed instruction pattern is binary 001
// [RQ12] shift-ir shifts the instruction stages; current instruction holds
// [RQ13] exit1-ir goes pause or update; pause holds, high goes exit2-ir
// [RQ14] exit2-ir: high goes update-ir, low resumes shift-ir
// [RQ15] the latched code becomes current; then idle or select-dr
// [RQ16] instruction register: three shift stages and three latched bits
// [RQ17] 010 sample/preload, 000 extest select boundary; 111 bypass
// [RQ18] 011 clamp, 100 highz; 001 idcode selects identification
// [RQ19] sample/preload captures pin states and lets new data shift in
// [RQ20] extest drives outputs from boundary latches and captures inputs
// [RQ21] bypass passes scan data through one stage
// [RQ22] idcode captures the device code; test-logic-reset forces idcode
// [RQ23] id code: marker 1, 11-bit maker, 16-bit device, 4-bit version
// [RQ24] highz floats every digital output, bypass in the serial path
// [RQ25] clamp drives outputs from boundary latches, bypass in serial path
// [RQ26] boundary register has 126 shift stages and latched outputs
// [RQ27] identification register has 32 shift stages and 32 latched bits
// [RQ28] scan reset or five clocks with mode select high reach reset
module bst_tap #(
    parameter int                               BSR_LEN  = bst_pkg::BSR_LEN,
    // identity values below are arbitrary
    parameter logic [bst_pkg::ID_VER_LEN-1:0]   VER_CODE = 4'h1,
    parameter logic [bst_pkg::ID_DEV_LEN-1:0]   DEV_CODE = 16'hA5C3,
    parameter logic [bst_pkg::ID_MFR_LEN-1:0]   MFR_CODE = 11'h2B6
) (
    input  wire logic               ref_clk_i,
    input  wire logic               reset_i,
    input  wire logic               scan_clock_pin_i,
    input  wire logic               scan_mode_select_pin_i,
    input  wire logic               scan_data_in_pin_i,
    input  wire logic               scan_reset_n_pin_i,
    input  wire logic [BSR_LEN-1:0] pin_sample_i,
    output logic                    scan_data_out_pin_o,
    output logic                    scan_data_out_oe_o,
    output logic      [BSR_LEN-1:0] bsr_drive_o,
    output logic                    test_drive_en_o,
    output logic                    outputs_hiz_o
);

    localparam int IR_LEN = bst_pkg::IR_LEN;
    localparam int ID_LEN = bst_pkg::ID_LEN;

    typedef struct packed {
        logic                clk_prev;
        bst_pkg::bst_state_e state;
        logic [IR_LEN-1:0]   ir_shift;
        logic [IR_LEN-1:0]   ir_cur;
        logic                bypass;
        logic                tdo;
        logic                tdo_oe;
        logic                drive_en;
        logic                hiz;
    } bst_tap_s;

    bst_tap_s tap;
    bst_tap_s next_tap;

    logic [3:0]        pins_s;
    logic              clk_s;
    logic              tms_s;
    logic              tdi_s;
    logic              trst_n_s;
    logic              rise;
    logic              fall;
    logic              bsr_cap;
    logic              bsr_shift;
    logic              bsr_upd;
    logic              id_cap;
    logic              id_shift;
    logic              id_upd;
    logic              bsr_so;
    logic              id_so;
    logic [ID_LEN-1:0] id_value;

    // boundary register is selected by sample/preload and extest
    function automatic logic sel_bsr(input logic [IR_LEN-1:0] ir);
        sel_bsr = (ir == bst_pkg::IR_SAMPLE) || (ir == bst_pkg::IR_EXTEST); // RQ17
    endfunction

    // identification register is selected by idcode only
    function automatic logic sel_id(input logic [IR_LEN-1:0] ir);
        sel_id = (ir == bst_pkg::IR_IDCODE); // RQ18
    endfunction

    // every other code, clamp and highz among them, uses the bypass stage
    function automatic logic sel_byp(input logic [IR_LEN-1:0] ir);
        sel_byp = !sel_bsr(ir) && !sel_id(ir); // RQ21
    endfunction

    // standard sixteen-state transition table
    function automatic bst_pkg::bst_state_e tap_next(
        input bst_pkg::bst_state_e s,
        input logic                tms
    );
        case (s)
            bst_pkg::ST_RESET:    tap_next = tms ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
            bst_pkg::ST_IDLE:     tap_next = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
            bst_pkg::ST_SEL_DR:   tap_next = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR; // RQ3
            bst_pkg::ST_CAP_DR:   tap_next = tms ? bst_pkg::ST_EXIT1_DR
                                                 : bst_pkg::ST_SHIFT_DR; // RQ4
            bst_pkg::ST_SHIFT_DR: tap_next = tms ? bst_pkg::ST_EXIT1_DR
                                                 : bst_pkg::ST_SHIFT_DR;
            bst_pkg::ST_EXIT1_DR: tap_next = tms ? bst_pkg::ST_UPD_DR
                                                 : bst_pkg::ST_PAUSE_DR; // RQ6
            bst_pkg::ST_PAUSE_DR: tap_next = tms ? bst_pkg::ST_EXIT2_DR
                                                 : bst_pkg::ST_PAUSE_DR; // RQ6
            bst_pkg::ST_EXIT2_DR: tap_next = tms ? bst_pkg::ST_UPD_DR
                                                 : bst_pkg::ST_SHIFT_DR; // RQ7
            bst_pkg::ST_UPD_DR:   tap_next = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE; // RQ8
            bst_pkg::ST_SEL_IR:   tap_next = tms ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR; // RQ9
            bst_pkg::ST_CAP_IR:   tap_next = tms ? bst_pkg::ST_EXIT1_IR
                                                 : bst_pkg::ST_SHIFT_IR; // RQ10
            bst_pkg::ST_SHIFT_IR: tap_next = tms ? bst_pkg::ST_EXIT1_IR
                                                 : bst_pkg::ST_SHIFT_IR; // RQ12
            bst_pkg::ST_EXIT1_IR: tap_next = tms ? bst_pkg::ST_UPD_IR
                                                 : bst_pkg::ST_PAUSE_IR; // RQ13
            bst_pkg::ST_PAUSE_IR: tap_next = tms ? bst_pkg::ST_EXIT2_IR
                                                 : bst_pkg::ST_PAUSE_IR; // RQ13
            // the standard ordering wins over the reversed printed levels
            bst_pkg::ST_EXIT2_IR: tap_next = tms ? bst_pkg::ST_UPD_IR
                                                 : bst_pkg::ST_SHIFT_IR; // RQ14
            bst_pkg::ST_UPD_IR:   tap_next = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE; // RQ15
            default:              tap_next = bst_pkg::ST_RESET;
        endcase
    endfunction

    // every scan pin passes two flops before any logic reads it
    bst_sync #(
        .WIDTH (4)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .async_i   ({scan_reset_n_pin_i, scan_data_in_pin_i,
                     scan_mode_select_pin_i, scan_clock_pin_i}),
        .sync_o    (pins_s)
    );

    assign clk_s    = pins_s[0];
    assign tms_s    = pins_s[1];
    assign tdi_s    = pins_s[2];
    assign trst_n_s = pins_s[3];

    // scan clock edges found on the synchronised level
    assign rise = clk_s && !tap.clk_prev; // RQ1
    assign fall = !clk_s && tap.clk_prev;

    // identification code, marker at the least significant end
    assign id_value = {VER_CODE, DEV_CODE, MFR_CODE, bst_pkg::ID_MARKER}; // RQ23

    // data register strobes; unselected registers see none and so hold
    always_comb begin
        bsr_cap   = rise && (tap.state == bst_pkg::ST_CAP_DR) && sel_bsr(tap.ir_cur); // RQ19
        bsr_shift = rise && (tap.state == bst_pkg::ST_SHIFT_DR) && sel_bsr(tap.ir_cur); // RQ5
        bsr_upd   = fall && (tap.state == bst_pkg::ST_UPD_DR) && sel_bsr(tap.ir_cur); // RQ8
        id_cap    = rise && (tap.state == bst_pkg::ST_CAP_DR) && sel_id(tap.ir_cur); // RQ22
        id_shift  = rise && (tap.state == bst_pkg::ST_SHIFT_DR) && sel_id(tap.ir_cur); // RQ22
        id_upd    = fall && (tap.state == bst_pkg::ST_UPD_DR) && sel_id(tap.ir_cur);
    end

    // boundary register: pin snapshot in, latched drive values out
    bst_dreg #(
        .WIDTH (BSR_LEN)
    ) u_bsr ( // RQ26
        .ref_clk_i      (ref_clk_i),
        .reset_i        (reset_i),
        .capture_i      (bsr_cap),
        .shift_i        (bsr_shift),
        .update_i       (bsr_upd),
        .capture_data_i (pin_sample_i), // RQ20
        .serial_i       (tdi_s),
        .serial_o       (bsr_so),
        .par_o          (bsr_drive_o)
    );

    // identification register; its latched side has no consumer here
    bst_dreg #(
        .WIDTH (ID_LEN)
    ) u_id ( // RQ27
        .ref_clk_i      (ref_clk_i),
        .reset_i        (reset_i),
        .capture_i      (id_cap),
        .shift_i        (id_shift),
        .update_i       (id_upd),
        .capture_data_i (id_value),
        .serial_i       (tdi_s),
        .serial_o       (id_so),
        .par_o          ()
    );

    // controller, instruction register, bypass stage and scan output
    always_comb begin
        next_tap          = tap;
        // parked high while scan reset is seen, so release brings no false rise
        next_tap.clk_prev = trst_n_s ? clk_s : 1'h1;

        if (rise) begin
            next_tap.state = tap_next(tap.state, tms_s); // RQ1
        end

        // instruction shift stages; capture and shift only on rising edges
        if (rise && (tap.state == bst_pkg::ST_CAP_IR)) begin
            next_tap.ir_shift = bst_pkg::IR_CAPTURE; // RQ10 RQ11
        end else if (rise && (tap.state == bst_pkg::ST_SHIFT_IR)) begin
            next_tap.ir_shift = {tdi_s, tap.ir_shift[IR_LEN-1:1]}; // RQ12 RQ16
        end

        // the code becomes current on the falling edge inside update-ir
        if (fall && (tap.state == bst_pkg::ST_UPD_IR)) begin
            next_tap.ir_cur = tap.ir_shift; // RQ14 RQ15
        end

        // bypass stage: loads zero on capture, one stage on shift
        if (sel_byp(tap.ir_cur)) begin
            if (rise && (tap.state == bst_pkg::ST_CAP_DR)) begin
                next_tap.bypass = bst_pkg::BYPASS_CAPTURE; // RQ4
            end else if (rise && (tap.state == bst_pkg::ST_SHIFT_DR)) begin
                next_tap.bypass = tdi_s; // RQ21 RQ24 RQ25
            end
        end

        // scan output changes on falling edges, as the tester expects
        if (fall) begin
            next_tap.tdo_oe = (tap.state == bst_pkg::ST_SHIFT_DR) ||
                              (tap.state == bst_pkg::ST_SHIFT_IR);
            if (tap.state == bst_pkg::ST_SHIFT_IR) begin
                next_tap.tdo = tap.ir_shift[0];
            end else if (sel_bsr(tap.ir_cur)) begin
                next_tap.tdo = bsr_so;
            end else if (sel_id(tap.ir_cur)) begin
                next_tap.tdo = id_so;
            end else begin
                next_tap.tdo = tap.bypass;
            end
        end

        // scan reset acts without waiting for any scan clock edge
        if (!trst_n_s) begin
            next_tap.state = bst_pkg::ST_RESET; // RQ28
        end

        // test-logic-reset keeps idcode current and pins in normal use
        if (next_tap.state == bst_pkg::ST_RESET) begin
            next_tap.ir_cur = bst_pkg::IR_RESET; // RQ2 RQ22
            next_tap.tdo_oe = 1'h0;
        end

        // pin control follows the current instruction in the same cycle
        next_tap.drive_en = (next_tap.ir_cur == bst_pkg::IR_EXTEST) ||
                            (next_tap.ir_cur == bst_pkg::IR_CLAMP); // RQ20 RQ25
        next_tap.hiz      = (next_tap.ir_cur == bst_pkg::IR_HIGHZ); // RQ24
    end

    // a reset value that keeps the pins in normal system use
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tap.clk_prev <= 1'h1;
            tap.state    <= bst_pkg::ST_RESET; // RQ2
            tap.ir_shift <= bst_pkg::IR_CAPTURE;
            tap.ir_cur   <= bst_pkg::IR_RESET;
            tap.bypass   <= bst_pkg::BYPASS_CAPTURE;
            tap.tdo      <= 1'h0;
            tap.tdo_oe   <= 1'h0;
            tap.drive_en <= 1'h0;
            tap.hiz      <= 1'h0;
        end else begin
            tap <= next_tap;
        end
    end

    assign scan_data_out_pin_o = tap.tdo;
    assign scan_data_out_oe_o  = tap.tdo_oe;
    assign test_drive_en_o     = tap.drive_en;
    assign outputs_hiz_o       = tap.hiz;

endmodule

// ==== core/bst_pkg.sv ====
// shared constants and types of the boundary-scan test access port
// assumes nothing of its surroundings; used by bst_tap, its monitor and the bench, not by bst_sync, bst_dreg or the tester
package bst_pkg;

    // register lengths
    localparam int IR_LEN      = 3;
    localparam int BSR_LEN     = 126;
    localparam int ID_LEN      = 32;
    localparam int ID_MFR_LEN  = 11;
    localparam int ID_DEV_LEN  = 16;
    localparam int ID_VER_LEN  = 4;

    // two flip-flops between a pin and the first logic that reads it
    localparam int SYNC_STAGES = 2;

    // instruction codes
    localparam logic [IR_LEN-1:0] IR_EXTEST  = 3'h0;
    localparam logic [IR_LEN-1:0] IR_IDCODE  = 3'h1;
    localparam logic [IR_LEN-1:0] IR_SAMPLE  = 3'h2;
    localparam logic [IR_LEN-1:0] IR_CLAMP   = 3'h3;
    localparam logic [IR_LEN-1:0] IR_HIGHZ   = 3'h4;
    localparam logic [IR_LEN-1:0] IR_BYPASS  = 3'h7;

    // fixed pattern loaded into the instruction shift stages in capture-ir
    localparam logic [IR_LEN-1:0] IR_CAPTURE = 3'h1;
    // instruction after reset and in test-logic-reset
    localparam logic [IR_LEN-1:0] IR_RESET   = IR_IDCODE;

    // constant least significant bit of the identification code
    localparam logic ID_MARKER = 1'h1;

    // value of the bypass stage after capture-dr
    localparam logic BYPASS_CAPTURE = 1'h0;

    // tap controller states
    typedef enum logic [3:0] {
        ST_RESET,
        ST_IDLE,
        ST_SEL_DR,
        ST_CAP_DR,
        ST_SHIFT_DR,
        ST_EXIT1_DR,
        ST_PAUSE_DR,
        ST_EXIT2_DR,
        ST_UPD_DR,
        ST_SEL_IR,
        ST_CAP_IR,
        ST_SHIFT_IR,
        ST_EXIT1_IR,
        ST_PAUSE_IR,
        ST_EXIT2_IR,
        ST_UPD_IR
    } bst_state_e;

endpackage

// ==== core/bst_sync.sv ====
// two-stage synchroniser for a group of asynchronous pin levels
// assumes each bit is a slow level; bits may resolve one cycle apart
`timescale 1ns/1ps

module bst_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } bst_sync_s;

    bst_sync_s sync;
    bst_sync_s next_sync;

    // the first stage is read only by the second
    always_comb begin
        next_sync.meta   = async_i;
        next_sync.stable = sync.meta;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync <= '0;
        end else begin
            sync <= next_sync;
        end
    end

    assign sync_o = sync.stable;

endmodule

// ==== core/bst_dreg.sv ====
// test data register: serial shift stages plus a latched parallel output
// assumes capture, shift and update are one-cycle strobes on ref_clk_i
`timescale 1ns/1ps

module bst_dreg #(
    parameter int WIDTH = 32
) (
    input  wire logic             ref_clk_i,
    input  wire logic             reset_i,
    input  wire logic             capture_i,
    input  wire logic             shift_i,
    input  wire logic             update_i,
    input  wire logic [WIDTH-1:0] capture_data_i,
    input  wire logic             serial_i,
    output logic                  serial_o,
    output logic      [WIDTH-1:0] par_o
);

    typedef struct packed {
        logic [WIDTH-1:0] stage;
        logic [WIDTH-1:0] latch;
    } bst_dreg_s;

    bst_dreg_s dreg;
    bst_dreg_s next_dreg;

    // stage 0 faces the serial output; new data enters at the top
    always_comb begin
        next_dreg = dreg;
        if (capture_i) begin
            next_dreg.stage = capture_data_i;
        end else if (shift_i) begin
            next_dreg.stage = {serial_i, dreg.stage[WIDTH-1:1]};
        end
        // latch only on update so the parallel side never ripples
        if (update_i) begin
            next_dreg.latch = dreg.stage;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            dreg <= '0;
        end else begin
            dreg <= next_dreg;
        end
    end

    assign serial_o = dreg.stage[0];
    assign par_o    = dreg.latch;

endmodule

// ==== testbench/bst_tap_monitor.sv ====
// concurrent checks on the ports of the boundary-scan test access port
// assumes scan pin levels change off the clock edge and last 8 cycles
`timescale 1ns/1ps

module bst_tap_monitor #(
    parameter int BSR_LEN = bst_pkg::BSR_LEN
) (
    input wire logic               ref_clk_i,
    input wire logic               reset_i,
    input wire logic               scan_clock_pin_i,
    input wire logic               scan_reset_n_pin_i,
    input wire logic               scan_data_out_pin_o,
    input wire logic               scan_data_out_oe_o,
    input wire logic [BSR_LEN-1:0] bsr_drive_o,
    input wire logic               test_drive_en_o,
    input wire logic               outputs_hiz_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    // pin effects trail a scan clock fall by the sync flops
    property p_reset_quiet;
        $fell(reset_i) |-> !test_drive_en_o && !outputs_hiz_o && !scan_data_out_oe_o
            && (bsr_drive_o == '0);
    endproperty
    property p_scan_reset;
        !scan_reset_n_pin_i [*5] |-> !test_drive_en_o && !outputs_hiz_o && !scan_data_out_oe_o;
    endproperty
    property p_exclusive;
        !(test_drive_en_o && outputs_hiz_o);
    endproperty
    property p_bsr_update;
        $changed(bsr_drive_o) |-> !scan_data_out_oe_o && !$past(scan_clock_pin_i, 2)
            && !$past(scan_clock_pin_i, 3);
    endproperty
    property p_oe_rise;
        $rose(scan_data_out_oe_o) |-> !$past(scan_clock_pin_i, 2);
    endproperty
    // scan reset may move data out, so its window is excluded
    property p_tdo_hold;
        scan_clock_pin_i && $past(scan_clock_pin_i, 4) && scan_reset_n_pin_i
            && $past(scan_reset_n_pin_i, 4) |-> $stable(scan_data_out_pin_o);
    endproperty
    property p_instr_rise;
        $rose(test_drive_en_o) || $rose(outputs_hiz_o) |-> !$past(scan_clock_pin_i, 2);
    endproperty
    property p_hiz_hold;
        outputs_hiz_o && $past(outputs_hiz_o) |-> $stable(bsr_drive_o);
    endproperty

    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
    a_scan_reset: assert property (p_scan_reset) else $error("scan reset ignored");
    a_exclusive: assert property (p_exclusive) else $error("drive and float together");
    a_bsr_update: assert property (p_bsr_update) else $error("boundary latch moved");
    a_oe_rise: assert property (p_oe_rise) else $error("data out enable off fall");
    a_tdo_hold: assert property (p_tdo_hold) else $error("data out moved while high");
    a_instr_rise: assert property (p_instr_rise) else $error("instruction off fall");
    a_hiz_hold: assert property (p_hiz_hold) else $error("latch moved while floating");

    c_drive: cover property ($rose(test_drive_en_o));
    c_hiz: cover property ($rose(outputs_hiz_o));
    c_shift: cover property ($rose(scan_data_out_oe_o));
endmodule

bind bst_tap bst_tap_monitor #(.BSR_LEN(BSR_LEN)) bst_tap_monitor_i (.*);

// ==== testbench/bst_tester.sv ====
// behavioural boundary-scan tester driving the scan pins of the port
// assumes the 100 MHz bench clock; one scan clock period is 17 of its cycles
`timescale 1ns/1ps

module bst_tester (
    input  wire logic ref_clk_i,
    input  wire logic scan_data_out_pin_i,
    input  wire logic scan_data_out_oe_i,
    output logic      scan_clock_pin_o,
    output logic      scan_mode_select_pin_o,
    output logic      scan_data_in_pin_o,
    output logic      scan_reset_n_pin_o
);
    // scan clock parks high between frames
    initial begin
        scan_clock_pin_o = 1'h1;
        scan_mode_select_pin_o = 1'h0;
        scan_data_in_pin_o = 1'h0;
        scan_reset_n_pin_o = 1'h1;
    end

    // one scan cycle: levels set at the fall, data out read just before the rise
    task automatic scan_bit(input logic tms, input logic tdi, output logic tdo);
        @(negedge ref_clk_i);
        scan_clock_pin_o = 1'h0;
        scan_mode_select_pin_o = tms;
        scan_data_in_pin_o = tdi;
        repeat (8) @(negedge ref_clk_i);
        tdo = scan_data_out_oe_i ? scan_data_out_pin_i : 1'hX;
        scan_clock_pin_o = 1'h1;
        repeat (4) @(negedge ref_clk_i);
        // past hold time: opposite levels catch late sampling
        scan_mode_select_pin_o = ~tms;
        scan_data_in_pin_o = ~tdi;
        repeat (4) @(negedge ref_clk_i);
    endtask

    // five high mode select levels, then one low to park in run-test-idle
    task automatic tap_reset();
        logic t;
        repeat (5) scan_bit(1'h1, 1'h0, t);
        scan_bit(1'h0, 1'h0, t);
    endtask

    // scan reset pulse with the scan clock standing still
    task automatic scan_reset();
        logic t;
        @(negedge ref_clk_i);
        scan_reset_n_pin_o = 1'h0;
        repeat (8) @(negedge ref_clk_i);
        scan_reset_n_pin_o = 1'h1;
        repeat (4) @(negedge ref_clk_i);
        scan_bit(1'h0, 1'h0, t);
    endtask
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the boundary-scan test access port
// assumes the tester model drives the scan pins
`timescale 1ns/1ps

module tb;
    // identity fields handed to the design; values are arbitrary
    localparam logic [bst_pkg::ID_VER_LEN-1:0] ID_VER = 4'h6;
    localparam logic [bst_pkg::ID_DEV_LEN-1:0] ID_DEV = 16'h3C5A;
    localparam logic [bst_pkg::ID_MFR_LEN-1:0] ID_MFR = 11'h1D3;
    localparam logic [127:0] PAT_A = {4{32'hC3A5_1E0F}};
    localparam logic [127:0] PAT_B = {4{32'h96E1_7D2B}};

    logic                        ref_clk_i;
    logic                        reset_i;
    logic [bst_pkg::BSR_LEN-1:0] pin_sample_i;
    logic                        scan_clock_pin_i;
    logic                        scan_mode_select_pin_i;
    logic                        scan_data_in_pin_i;
    logic                        scan_reset_n_pin_i;
    logic                        scan_data_out_pin_o;
    logic                        scan_data_out_oe_o;
    logic [bst_pkg::BSR_LEN-1:0] bsr_drive_o;
    logic                        test_drive_en_o;
    logic                        outputs_hiz_o;
    logic [127:0]                d;
    int                          errors;
    int                          checks;

    bst_tap #(.VER_CODE(ID_VER), .DEV_CODE(ID_DEV), .MFR_CODE(ID_MFR)) bst_tap_i (.*);

    bst_tester tester_i (
        .ref_clk_i             (ref_clk_i),
        .scan_data_out_pin_i   (scan_data_out_pin_o),
        .scan_data_out_oe_i    (scan_data_out_oe_o),
        .scan_clock_pin_o      (scan_clock_pin_i),
        .scan_mode_select_pin_o(scan_mode_select_pin_i),
        .scan_data_in_pin_o    (scan_data_in_pin_i),
        .scan_reset_n_pin_o    (scan_reset_n_pin_i)
    );

    initial begin
        ref_clk_i = 1'h0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    task automatic check(input string name, input logic [127:0] exp, input logic [127:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        if (errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // full scan from run-test-idle; pause_at >= n means no pause
    task automatic scan(input logic ir, input int n, input logic [127:0] din, input int pause_at,
                        output logic [127:0] dout);
        logic t;
        dout = '0;
        tester_i.scan_bit(1'h1, 1'h0, t);
        if (ir) tester_i.scan_bit(1'h1, 1'h0, t);
        tester_i.scan_bit(1'h0, 1'h0, t);
        tester_i.scan_bit(1'h0, 1'h0, t);
        for (int i = 0; i < n; i++) begin
            if (i == pause_at) begin
                // exit1 to pause, stay, exit2, back to shift
                tester_i.scan_bit(1'h0, 1'h0, t);
                tester_i.scan_bit(1'h0, 1'h0, t);
                tester_i.scan_bit(1'h1, 1'h0, t);
                tester_i.scan_bit(1'h0, 1'h0, t);
            end
            tester_i.scan_bit(i == n - 1 || i == pause_at - 1, din[i], dout[i]);
        end
        tester_i.scan_bit(1'h1, 1'h0, t);
        tester_i.scan_bit(1'h0, 1'h0, t);
    endtask

    task automatic load(input logic [2:0] code);
        scan(1'h1, 3, 128'(code), 200, d);
        check("ir capture", 128'h1, 128'(d[2:0]));
    endtask

    task automatic flags(input logic en, input logic hz);
        check("test_drive_en_o", 128'(en), 128'(test_drive_en_o));
        check("outputs_hiz_o", 128'(hz), 128'(outputs_hiz_o));
    endtask

    task automatic id_ok();
        scan(1'h0, 32, '0, 200, d);
        check("idcode", 128'({ID_VER, ID_DEV, ID_MFR, 1'h1}), 128'(d[31:0]));
    endtask

    // one stage delay, capture value 0 leads the stream
    task automatic bypass_ok();
        scan(1'h0, 8, 128'hB5, 200, d);
        check("bypass out", 128'h6A, 128'(d[7:0]));
    endtask

    task automatic t_bypass();
        for (int k = 5; k < 8; k++) begin
            load(3'(k));
            flags(1'h0, 1'h0);
            bypass_ok();
        end
    endtask

    task automatic t_sample();
        pin_sample_i = PAT_A[125:0];
        load(bst_pkg::IR_SAMPLE);
        flags(1'h0, 1'h0);
        scan(1'h0, 126, PAT_B, 200, d);
        check("bsr capture", 128'(PAT_A[125:0]), 128'(d[125:0]));
        check("bsr latch", 128'(PAT_B[125:0]), 128'(bsr_drive_o));
    endtask

    task automatic t_extest();
        load(bst_pkg::IR_EXTEST);
        flags(1'h1, 1'h0);
        pin_sample_i = PAT_B[125:0];
        scan(1'h0, 126, PAT_A, 60, d);
        check("bsr capture", 128'(PAT_B[125:0]), 128'(d[125:0]));
        check("bsr latch", 128'(PAT_A[125:0]), 128'(bsr_drive_o));
    endtask

    task automatic t_clamp_highz();
        load(bst_pkg::IR_CLAMP);
        flags(1'h1, 1'h0);
        bypass_ok();
        check("bsr held", 128'(PAT_A[125:0]), 128'(bsr_drive_o));
        load(bst_pkg::IR_HIGHZ);
        flags(1'h0, 1'h1);
        bypass_ok();
        check("bsr held", 128'(PAT_A[125:0]), 128'(bsr_drive_o));
    endtask

    task automatic t_ir_pause();
        scan(1'h1, 3, 128'(bst_pkg::IR_EXTEST), 1, d);
        check("ir capture", 128'h1, 128'(d[2:0]));
        flags(1'h1, 1'h0);
    endtask

    // leave shift-dr mid-scan by five high levels
    task automatic t_five();
        logic t;
        tester_i.scan_bit(1'h1, 1'h0, t);
        tester_i.scan_bit(1'h0, 1'h0, t);
        tester_i.scan_bit(1'h0, 1'h0, t);
        tester_i.tap_reset();
        flags(1'h0, 1'h0);
        id_ok();
    endtask

    task automatic t_srst();
        load(bst_pkg::IR_HIGHZ);
        tester_i.scan_reset();
        flags(1'h0, 1'h0);
        id_ok();
    endtask

    initial begin
        #300_000;
        errors++;
        tally_and_finish();
    end

    initial begin
        errors = 0;
        checks = 0;
        reset_i = 1'h1;
        pin_sample_i = '0;
        repeat (16) @(negedge ref_clk_i);
        reset_i = 1'h0;
        repeat (4) @(negedge ref_clk_i);
        flags(1'h0, 1'h0);
        tester_i.scan_bit(1'h0, 1'h0, d[0]);
        id_ok();
        t_bypass();
        t_sample();
        t_extest();
        t_clamp_highz();
        t_ir_pause();
        t_five();
        t_srst();
        tally_and_finish();
    end
endmodule
